// file: hw/asf_string_to_float.sv
// String to float converter with AHB-Lite register access
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asf_consts.svh"

module asf_string_to_float
	import asf_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Completion and interrupt
	output logic             done,
	output logic             irq
);

	// ==========================================================
	// Helpers
	function automatic logic is_digit(input logic [7:0] c);
		return (c >= `ASF_CH_ZERO) && (c <= `ASF_CH_NINE);
	endfunction : is_digit

	function automatic logic is_sign(input logic [7:0] c);
		return (c == `ASF_CH_PLUS) || (c == `ASF_CH_MINUS);
	endfunction : is_sign

	// ==========================================================
	// Declarations
	asf_ahb_t          aph_ff;
	asf_state_t        state_ff;
	asf_flags_t        res_ff;
	logic [15:0]       src_ff [`ASF_SRC_WORDS];
	logic [4:0]        idx_ff;
	logic [23:0]       man_ff;
	logic [3:0]        sig_ff;
	logic signed [10:0] dexp_ff;
	logic [9:0]        string_to_real_op_ff;
	logic              neg_ff;
	logic              eneg_ff;
	logic              esign_ff;
	logic              edig_ff;
	logic              pt_ff;
	logic              e_ff;
	logic              mseen_ff;
	logic              nz_ff;
	logic [31:0]       m_ff;
	logic signed [10:0] be_ff;
	logic signed [10:0] cnt_ff;
	logic [15:0]       code_ff;
	logic [15:0]       dlo_ff;
	logic [15:0]       dhi_ff;
	logic              done_ff;
	logic [1:0]        ist_ff;
	logic [1:0]        msk_ff;
	logic [15:0]       cw;
	logic [7:0]        ch;
	logic              sc_fmt;
	logic              sc_len;
	logic              sc_end;
	logic              scan_fail;
	logic              wr_en;
	logic              start;
	logic              fin_now;
	logic [3:0]        dval;
	logic [27:0]       man_nxt;
	logic [13:0]       string_to_real_op_nxt;
	logic signed [10:0] texp;
	logic [63:0]       prod;
	logic signed [10:0] bexp;
	logic              scale_stop;

	// ==========================================================
	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_en     = aph_ff.valid & aph_ff.write;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_ff <= '0;
		end else if (hready) begin
			aph_ff.valid <= hsel & htrans[1];
			aph_ff.write <= hwrite;
			aph_ff.off   <= haddr[7:0];
		end
	end

	always_comb begin
		hrdata = 32'h0000_0000;
		if (aph_ff.valid && !aph_ff.write) begin
			unique case (aph_ff.off)
				`ASF_OFF_STAT: hrdata = {27'h0, state_ff != ST_IDLE, res_ff};
				`ASF_OFF_CODE: hrdata = {16'h0000, code_ff};
				`ASF_OFF_DLO:  hrdata = {16'h0000, dlo_ff};
				`ASF_OFF_DHI:  hrdata = {16'h0000, dhi_ff};
				`ASF_OFF_IST:  hrdata = {30'h0, ist_ff};
				`ASF_OFF_IMSK: hrdata = {30'h0, msk_ff};
				default: begin
					for (int i = 0; i < `ASF_SRC_WORDS; i++) begin
						if (aph_ff.off == 8'(`ASF_OFF_SRC + 4 * i))
							hrdata = {16'h0000, src_ff[i]};
					end
				end
			endcase
		end
	end

	// Source words are frozen while a conversion runs
	generate
		for (genvar g = 0; g < `ASF_SRC_WORDS; g++) begin : g_src
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					src_ff[g] <= `ASF_RST_WORD;
				else if (wr_en && aph_ff.off == 8'(`ASF_OFF_SRC + 4 * g)
					&& state_ff == ST_IDLE)
					src_ff[g] <= hwdata[15:0];
			end
		end
	endgenerate

	assign start = wr_en && aph_ff.off == `ASF_OFF_CTRL
		&& hwdata[`ASF_CTRL_START] && state_ff == ST_IDLE;

	// ==========================================================
	// Character fetch and classification
	assign cw = src_ff[idx_ff[4:1]];
	assign ch = idx_ff[0] ? cw[15:8] : cw[7:0];
	assign dval = 4'(ch - `ASF_CH_ZERO);

	always_comb begin
		sc_fmt = 1'b0;
		sc_len = 1'b0;
		sc_end = 1'b0;
		if (ch == `ASF_CH_NUL) begin
			sc_len = idx_ff == 5'h00;
			sc_end = idx_ff != 5'h00;
		end else if (idx_ff == `ASF_MAX_CHARS) begin
			sc_len = 1'b1;
		end else if (ch == `ASF_CH_SP) begin
			sc_fmt = 1'b0;
		end else if (e_ff) begin
			sc_fmt = !((is_sign(ch) && !esign_ff && !edig_ff)
				|| is_digit(ch));
		end else if (is_sign(ch)) begin
			sc_fmt = mseen_ff;
		end else if (ch == `ASF_CH_DOT) begin
			sc_fmt = pt_ff;
		end else begin
			sc_fmt = !(ch == `ASF_CH_EXP || is_digit(ch));
		end
	end

	assign scan_fail = (state_ff == ST_SCAN) && (sc_fmt || sc_len);
	assign man_nxt   = 28'(man_ff * 24'h00000A) + 28'(dval);
	assign string_to_real_op_nxt  = 14'(string_to_real_op_ff) * 14'h000A + 14'(dval);
	assign texp      = eneg_ff ? dexp_ff - 11'(string_to_real_op_ff) : dexp_ff + 11'(string_to_real_op_ff);

	// ==========================================================
	// Sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
		end else begin
			unique case (state_ff)
				ST_IDLE:  if (start) state_ff <= ST_SCAN;
				ST_SCAN: begin
					if (sc_fmt || sc_len)
						state_ff <= ST_IDLE;
					else if (sc_end)
						state_ff <= (man_ff == 24'h0) ? ST_PACK : ST_NORM;
				end
				ST_NORM:  if (m_ff[31]) state_ff <= ST_SCALE;
				ST_SCALE: if (scale_stop) state_ff <= ST_PACK;
				ST_PACK:  state_ff <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Parser state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_ff   <= 5'h00;
			man_ff   <= 24'h0;
			sig_ff   <= 4'h0;
			dexp_ff  <= 11'sh000;
			string_to_real_op_ff  <= 10'h000;
			neg_ff   <= 1'b0;
			eneg_ff  <= 1'b0;
			esign_ff <= 1'b0;
			edig_ff  <= 1'b0;
			pt_ff    <= 1'b0;
			e_ff     <= 1'b0;
			mseen_ff <= 1'b0;
			nz_ff    <= 1'b0;
		end else if (start) begin
			idx_ff   <= 5'h00;
			man_ff   <= 24'h0;
			sig_ff   <= 4'h0;
			dexp_ff  <= 11'sh000;
			string_to_real_op_ff  <= 10'h000;
			neg_ff   <= 1'b0;
			eneg_ff  <= 1'b0;
			esign_ff <= 1'b0;
			edig_ff  <= 1'b0;
			pt_ff    <= 1'b0;
			e_ff     <= 1'b0;
			mseen_ff <= 1'b0;
			nz_ff    <= 1'b0;
		end else if (state_ff == ST_SCAN && !sc_fmt && !sc_len && !sc_end) begin
			idx_ff <= idx_ff + 5'h01;
			if (ch == `ASF_CH_SP) begin
				idx_ff <= idx_ff + 5'h01;
			end else if (e_ff) begin
				if (is_sign(ch)) begin
					esign_ff <= 1'b1;
					eneg_ff  <= ch == `ASF_CH_MINUS;
				end else begin
					edig_ff <= 1'b1;
					string_to_real_op_ff <= (string_to_real_op_nxt > `ASF_EXP_SAT) ? 10'(`ASF_EXP_SAT) : string_to_real_op_nxt[9:0];
				end
			end else if (is_sign(ch)) begin
				mseen_ff <= 1'b1;
				neg_ff   <= ch == `ASF_CH_MINUS;
			end else if (ch == `ASF_CH_DOT) begin
				mseen_ff <= 1'b1;
				pt_ff    <= 1'b1;
			end else if (ch == `ASF_CH_EXP) begin
				e_ff <= 1'b1;
			end else begin
				mseen_ff <= 1'b1;
				if (nz_ff || ch != `ASF_CH_ZERO) begin
					nz_ff <= 1'b1;
					if (sig_ff < `ASF_SIG_MAX) begin
						man_ff <= man_nxt[23:0];
						sig_ff <= sig_ff + 4'h1;
						if (pt_ff)
							dexp_ff <= dexp_ff - 11'sh001;
					end else if (!pt_ff) begin
						// Dropped integer digits still carry magnitude
						dexp_ff <= dexp_ff + 11'sh001;
					end
				end else if (pt_ff) begin
					dexp_ff <= dexp_ff - 11'sh001;
				end
			end
		end
	end

	// ==========================================================
	// Binary scaling by powers of ten
	// Each step multiplies by 10 or 0.1 at 32-bit precision; the
	// truncation error is far below the seven-digit input.
	assign prod = 64'(m_ff) * 64'(cnt_ff[10] ? `ASF_K_DIV10 : `ASF_K_MUL10);
	assign scale_stop = (cnt_ff == 11'sh000) || (be_ff > `ASF_BE_LIM)
		|| (be_ff < -`ASF_BE_LIM);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			m_ff   <= 32'h0;
			be_ff  <= 11'sh000;
			cnt_ff <= 11'sh000;
		end else if (state_ff == ST_SCAN && sc_end && !sc_fmt && !sc_len) begin
			m_ff   <= {8'h00, man_ff};
			be_ff  <= `ASF_BE_INIT;
			cnt_ff <= texp;
		end else if (state_ff == ST_NORM && !m_ff[31]) begin
			m_ff  <= {m_ff[30:0], 1'b0};
			be_ff <= be_ff - 11'sh001;
		end else if (state_ff == ST_SCALE && !scale_stop) begin
			m_ff   <= prod[63] ? prod[63:32] : prod[62:31];
			be_ff  <= be_ff + (cnt_ff[10] ? -11'sh003 : 11'sh004)
				- (prod[63] ? 11'sh000 : 11'sh001);
			cnt_ff <= cnt_ff[10] ? cnt_ff + 11'sh001 : cnt_ff - 11'sh001;
		end
	end

	// ==========================================================
	// Result, flags and error code
	assign bexp    = be_ff + `ASF_BIAS;
	assign fin_now = (state_ff == ST_PACK) || scan_fail;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_ff  <= '0;
			code_ff <= `ASF_RST_WORD;
			dlo_ff  <= `ASF_RST_WORD;
			dhi_ff  <= `ASF_RST_WORD;
		end else if (start) begin
			res_ff <= '0;
		end else if (scan_fail) begin
			// Destination keeps its old value
			res_ff.err <= 1'b1;
			code_ff    <= sc_len ? `ASF_ERR_LEN : `ASF_ERR_FMT;
		end else if (state_ff == ST_PACK) begin
			if (man_ff == 24'h0) begin
				res_ff.zero <= 1'b1;
				{dhi_ff, dlo_ff} <= {neg_ff, 31'h0};
			end else if (bexp >= `ASF_BIASED_MAX) begin
				res_ff.carry <= 1'b1;
				{dhi_ff, dlo_ff} <= {neg_ff, `ASF_MAG_MAX};
			end else if (bexp < 11'sh001) begin
				res_ff.borrow <= 1'b1;
				{dhi_ff, dlo_ff} <= {neg_ff, 31'h0};
			end else begin
				{dhi_ff, dlo_ff} <= {neg_ff, bexp[7:0], m_ff[30:8]};
			end
		end
	end

	// ==========================================================
	// Completion and interrupt
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done_ff <= 1'b0;
		else
			done_ff <= fin_now;
	end
	assign done = done_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_ff <= 2'h0;
			msk_ff <= 2'h0;
		end else begin
			// A new event wins over a clear in the same cycle
			ist_ff <= (ist_ff & ~((wr_en && aph_ff.off == `ASF_OFF_IST) ? hwdata[1:0] : 2'h0))
				| {scan_fail, fin_now};
			if (wr_en && aph_ff.off == `ASF_OFF_IMSK)
				msk_ff <= hwdata[1:0];
		end
	end
	assign irq = |(ist_ff & msk_ff);

	// ==========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_start;
		start;
	endsequence
	sequence s_finish;
		##[2:300] done;
	endsequence
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_finish;
		s_start |-> s_finish;
	endproperty
	a_finish: assert property (p_finish) else $error("conversion did not finish");
	property p_err_code;
		done && res_ff.err |-> code_ff == `ASF_ERR_LEN || code_ff == `ASF_ERR_FMT;
	endproperty
	a_err_code: assert property (p_err_code) else $error("bad error code");
	property p_dest_kept;
		scan_fail |=> $stable(dlo_ff) && $stable(dhi_ff) && res_ff.err;
	endproperty
	a_dest_kept: assert property (p_dest_kept) else $error("destination changed on error");
	property p_empty;
		state_ff == ST_SCAN && idx_ff == 5'h00 && ch == `ASF_CH_NUL
			|=> code_ff == `ASF_ERR_LEN && done;
	endproperty
	a_empty: assert property (p_empty) else $error("empty string not refused");
	property p_two_dots;
		state_ff == ST_SCAN && pt_ff && !e_ff && ch == `ASF_CH_DOT
			&& idx_ff < `ASF_MAX_CHARS |=> code_ff == `ASF_ERR_FMT;
	endproperty
	a_two_dots: assert property (p_two_dots) else $error("second point not refused");
	property p_zero;
		done && res_ff.zero |-> dlo_ff == 16'h0 && dhi_ff[14:0] == 15'h0 && man_ff == 24'h0;
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag mismatch");
	property p_carry;
		done && res_ff.carry |-> {dhi_ff[14:0], dlo_ff} == `ASF_MAG_MAX;
	endproperty
	a_carry: assert property (p_carry) else $error("carry result not clamped");
	property p_borrow;
		done && res_ff.borrow |-> {dhi_ff[14:0], dlo_ff} == 31'h0;
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow result not discarded");
	property p_sign;
		done && !res_ff.err |-> dhi_ff[15] == neg_ff;
	endproperty
	a_sign: assert property (p_sign) else $error("result sign wrong");
endmodule : asf_string_to_float
`default_nettype wire

// file: shared/asf_consts.svh
// Offsets, field positions, codes and counts of the string to float converter
// Function
// - Store 32-bit float result in two words
// - Low byte first, then high byte
// - First 00H ends string; missing gives K6705
// - Ignore eighth and later significant digits
// - Leading 2BH or none positive, 2DH negative
// - Exponent sign 2BH positive, 2DH negative
// - Skip spaces and leading zeros
// - Length zero or above 24 gives K6705
// - Zero flag when mantissa is zero
// - Below 2^-126 discard and set borrow
// - At or above 2^128 clamp, set carry
// - Non-digit in mantissa gives K6706
// - Two decimal points give K6706
// - Bad exponent characters give K6706
// - Error sets flag and error code word
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

// ==========================================================
// Register offsets
`define ASF_OFF_CTRL   8'h00
`define ASF_OFF_STAT   8'h04
`define ASF_OFF_CODE   8'h08
`define ASF_OFF_DLO    8'h0C
`define ASF_OFF_DHI    8'h10
`define ASF_OFF_IST    8'h14
`define ASF_OFF_IMSK   8'h18
`define ASF_OFF_SRC    8'h40

// ==========================================================
// Field positions and reset values
`define ASF_CTRL_START 0
`define ASF_STAT_BUSY  4
`define ASF_IRQ_DONE   0
`define ASF_IRQ_ERR    1
`define ASF_RST_WORD   16'h0000

// ==========================================================
// Characters, limits and codes
`define ASF_SRC_WORDS  13
`define ASF_MAX_CHARS  5'h18
`define ASF_SIG_MAX    4'h7
`define ASF_CH_NUL     8'h00
`define ASF_CH_SP      8'h20
`define ASF_CH_PLUS    8'h2B
`define ASF_CH_MINUS   8'h2D
`define ASF_CH_DOT     8'h2E
`define ASF_CH_EXP     8'h45
`define ASF_CH_ZERO    8'h30
`define ASF_CH_NINE    8'h39
`define ASF_ERR_LEN    16'h1A31
`define ASF_ERR_FMT    16'h1A32

// ==========================================================
// Arithmetic
`define ASF_K_MUL10    32'hA0000000
`define ASF_K_DIV10    32'hCCCCCCCD
`define ASF_BE_INIT    11'sh01F
`define ASF_BE_LIM     11'sh0C8
`define ASF_EXP_SAT    14'h00C8
`define ASF_BIAS       11'sh07F
`define ASF_BIASED_MAX 11'sh0FF
`define ASF_MAG_MAX    31'h7F7FFFFF

`endif

// file: shared/asf_pkg.sv
// Types shared by the string to float converter
package asf_pkg;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SCAN,
		ST_NORM,
		ST_SCALE,
		ST_PACK
	} asf_state_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] off;
	} asf_ahb_t;

	typedef struct packed {
		logic err;
		logic carry;
		logic borrow;
		logic zero;
	} asf_flags_t;

endpackage : asf_pkg

// file: sim/asf_string_to_float_tb.sv
// Self-checking testbench of the string to float converter
`timescale 1ns/1ps
`default_nettype none
`include "asf_consts.svh"

module asf_string_to_float_tb;

	// ==========================================================
	// Signals
	logic        hclk        = 1'h0;
	logic        hresetn     = 1'h0;
	logic        hsel        = 1'h0;
	logic [31:0] haddr       = 32'h00000000;
	logic [1:0]  htrans      = 2'h0;
	logic        hwrite      = 1'h0;
	logic [2:0]  hsize       = 3'h2;
	logic [31:0] hwdata      = 32'h00000000;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         done;
	wire         irq;
	int          fails       = 0;
	int          check_count = 0;
	int          cyc         = 0;
	logic [31:0] rd;
	logic [31:0] last        = 32'h00000000;
	logic [1:0]  msk         = 2'h0;
	logic [7:0]  offs [9]    = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40, 8'h20};

	always #12.5 hclk = ~hclk;

	asf_string_to_float dut (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.done      (done),
		.irq       (irq)
	);

	// ==========================================================
	// Reporting
	task summarize;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Hang guard: a full run needs well under half of this
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end

	// ==========================================================
	// Bus access
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		// Taken before this edge's updates land, so it is the data-phase value
		rd = hrdata;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h00000000);
		chk(rd, exp);
		chk({31'h0, hresp}, 32'h00000000);
	endtask : rdchk

	// ==========================================================
	// Conversion
	task load(input string s);
		logic [7:0] lo;
		logic [7:0] hi;
		for (int k = 0; k < `ASF_SRC_WORDS; k++) begin
			lo = (2 * k < s.len()) ? s[2 * k] : 8'h00;
			hi = (2 * k + 1 < s.len()) ? s[2 * k + 1] : 8'h00;
			wr(`ASF_OFF_SRC + 8'(4 * k), {16'h0000, hi, lo});
		end
	endtask : load

	// Error runs expect the previous result to survive untouched
	task conv(input string s, input logic [3:0] st, input logic [31:0] res,
		input logic [15:0] code);
		int   n;
		logic e;
		e = st[3];
		if (!e) begin
			last = res;
		end
		load(s);
		wr(`ASF_OFF_CTRL, 32'h00000001);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (done !== 1'h1 && n < 400);
		chk({31'h0, done}, 32'h00000001);
		@(posedge hclk);
		chk({31'h0, done}, 32'h00000000);
		rdchk(`ASF_OFF_STAT, {28'h0, st});
		if (e) begin
			rdchk(`ASF_OFF_CODE, {16'h0000, code});
		end
		rdchk(`ASF_OFF_DLO, {16'h0000, last[15:0]});
		rdchk(`ASF_OFF_DHI, {16'h0000, last[31:16]});
		chk({31'h0, irq}, {31'h0, |(msk & {e, 1'h1})});
		rdchk(`ASF_OFF_IST, {30'h0, e, 1'h1});
		wr(`ASF_OFF_IST, 32'h00000003);
		rdchk(`ASF_OFF_IST, 32'h00000000);
		chk({31'h0, irq}, 32'h00000000);
	endtask : conv

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'h1;
		foreach (offs[i]) begin
			rdchk(offs[i], 32'h00000000);
		end
		wr(8'h20, 32'hFFFFFFFF);
		rdchk(8'h20, 32'h00000000);
		conv("1", 4'h0, 32'h3F800000, 16'h0000);
		wr(`ASF_OFF_IMSK, 32'h00000001);
		msk = 2'h1;
		rdchk(`ASF_OFF_IMSK, 32'h00000001);
		conv("-25", 4'h0, 32'hC1C80000, 16'h0000);
		conv("+2E+1", 4'h0, 32'h41A00000, 16'h0000);
		conv("12345678", 4'h0, 32'h4B3C6146, 16'h0000);
		conv(" 0 1 0 5", 4'h0, 32'h42D20000, 16'h0000);
		conv("1E-39", 4'h2, 32'h00000000, 16'h0000);
		conv("0", 4'h1, 32'h00000000, 16'h0000);
		conv("1E+39", 4'h4, 32'h7F7FFFFF, 16'h0000);
		conv("-1E+1030", 4'h4, 32'hFF7FFFFF, 16'h0000);
		conv("-0.25E+1", 4'h0, 32'hC0200000, 16'h0000);
		// Only the error event reaches the interrupt from here on
		wr(`ASF_OFF_IMSK, 32'h00000002);
		msk = 2'h2;
		conv("1.2.3", 4'h8, 32'h00000000, `ASF_ERR_FMT);
		conv("1A", 4'h8, 32'h00000000, `ASF_ERR_FMT);
		conv("1E+2E1", 4'h8, 32'h00000000, `ASF_ERR_FMT);
		conv("1E*2", 4'h8, 32'h00000000, `ASF_ERR_FMT);
		conv("", 4'h8, 32'h00000000, `ASF_ERR_LEN);
		conv("1111111111111111111111111", 4'h8, 32'h00000000, `ASF_ERR_LEN);
		conv("11111111111111111111111111", 4'h8, 32'h00000000, `ASF_ERR_LEN);
		conv("2", 4'h0, 32'h40000000, 16'h0000);
		summarize();
	end

endmodule : asf_string_to_float_tb

`default_nettype wire
